/* hw/rdc_pkg.sv */
// rdc_pkg: shared constants and types for the redriver control block
package rdc_pkg;

	// ---------------------------------------------------------------
	// clock and timing
	// ---------------------------------------------------------------
	localparam int CLK_MHZ          = 50;         // pclk rate
	localparam int CFG_HOLD_US      = 10;         // config_hold_interval
	localparam int CFG_HOLD_CYC     = CFG_HOLD_US * CLK_MHZ; // least: exact
	localparam int RXDET_INTV_MS    = 12;         // receiver detect period
	localparam int RXDET_INTV_CYC   = RXDET_INTV_MS * 1000 * CLK_MHZ;

	// ---------------------------------------------------------------
	// four-level strap codes
	// ---------------------------------------------------------------
	localparam logic [1:0] LVL_LOW    = 2'h0;   // strong low
	localparam logic [1:0] LVL_WLOW   = 2'h1;   // weak low
	localparam logic [1:0] LVL_OPEN   = 2'h2;   // floating
	localparam logic [1:0] LVL_HIGH   = 2'h3;   // strong high
	localparam logic [3:0] GAIN_MIN   = 4'h0;   // lowest setting

	// ---------------------------------------------------------------
	// apb register map (byte offsets)
	// ---------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL   = 8'h00;  // mode override
	localparam logic [7:0] OFS_GAIN1  = 8'h04;  // port one gain
	localparam logic [7:0] OFS_GAIN2  = 8'h08;  // port two gain
	localparam logic [7:0] OFS_GAINT  = 8'h0c;  // tx side gain
	localparam logic [7:0] OFS_STRAP  = 8'h10;  // latched straps
	localparam logic [7:0] OFS_STAT   = 8'h14;  // link state
	localparam logic [7:0] OFS_EQ     = 8'h18;  // applied gains

	// ---------------------------------------------------------------
	// link power state
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		LS_DISC,
		LS_U0,
		LS_U1,
		LS_U23
	} rdc_link_t;

endpackage : rdc_pkg

/* hw/rdc_sync3.sv */
// rdc_sync3: three-flop synchroniser with agreement filter
`timescale 1ns/1ps
module rdc_sync3 #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// pins
	input  wire logic [W-1:0] din,
	// synchronised level
	output logic      [W-1:0] dout
);
	// stage flops; s1 feeds only s2
	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	logic [W-1:0] s3_ff;
	logic [W-1:0] out_ff;
	logic [W-1:0] nxt_out;

	// accept a change only once stages two and three agree
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			assign nxt_out[i] = (s2_ff[i] == s3_ff[i]) ? s2_ff[i]
			                                           : out_ff[i];
		end
	endgenerate

	// shift chain
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_ff  <= '0;
			s2_ff  <= '0;
			s3_ff  <= '0;
			out_ff <= '0;
		end else begin
			s1_ff  <= din;
			s2_ff  <= s1_ff;
			s3_ff  <= s2_ff;
			out_ff <= nxt_out;
		end
	end

	assign dout = out_ff;

endmodule : rdc_sync3

/* hw/rdc_top.sv */
// rdc_top: strap latch, equalization select and link state tracking
`timescale 1ns/1ps

// Behaviour
// - poll far-end receiver until one is found, and again while in u2/u3
// - after detection enable receive termination
// - lfps present disables equalization on path
// - otherwise apply strap or register gain
// - latch four-level straps at reset release
// - drop strap bias after hold interval
// - each strap resolves to one level
// - strap pair gives one of sixteen gains
// - rx ports share one strap pair, tx side has its own
// - rx ports and tx side controlled separately
// - serial strap chooses strap or register mode
// - link state from phy conditions and the detect period timer, held disconnected until straps are captured
// - levels encode 0,R,F,1 as 00..11
// - higher strap forms upper gain half
// - disconnected goes to u0 on both terminations
// - lfps in u2/u3 returns to u0
module rdc_top #(
	parameter int RXDET_CYC = rdc_pkg::RXDET_INTV_CYC // detect period
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// internal power-good reset, rises to start config
	input  wire logic        power_good,
	// four-level straps, already resolved by the analog comparator
	input  wire logic [3:0]  rx_port_gain_straps,  // {hi,lo} 2-bit codes
	input  wire logic [3:0]  tx_side_gain_straps,  // {hi,lo} 2-bit codes
	input  wire logic [1:0]  serial_cfg_strap,     // register mode strap
	// phy conditions
	input  wire logic [1:0]  far_term_seen,        // {dfp,ufp} rx found
	input  wire logic [1:0]  elec_idle,            // {dfp,ufp}
	input  wire logic [2:0]  lfps_seen,            // {tx,p2,p1}
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// analog controls
	output logic             rx_detect_pulse,      // start detect cycle
	output logic             rx_term_en,           // own termination on
	output logic             strap_bias_en,        // strap pull network
	output logic      [3:0]  port_one_eq,          // applied gain
	output logic      [3:0]  port_two_eq,
	output logic      [3:0]  tx_side_eq,
	output logic      [1:0]  link_state            // 0 disc,1 u0,2 u1,3 u23
);
	import rdc_pkg::*;

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	logic        pg_s;                          // synced power good
	logic [3:0]  rxs_s;                         // synced rx straps
	logic [3:0]  txs_s;                         // synced tx straps
	logic [1:0]  ser_s;                         // synced serial strap
	logic [1:0]  term_s;                        // synced terminations
	logic [1:0]  idle_s;                        // synced idle
	logic [2:0]  lfps_s;                        // synced lfps

	rdc_sync3 #(.W(18)) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.din     ({power_good, rx_port_gain_straps, tx_side_gain_straps,
		           serial_cfg_strap, far_term_seen, elec_idle, lfps_seen}),
		.dout    ({pg_s, rxs_s, txs_s, ser_s, term_s, idle_s, lfps_s})
	);

	// ---------------------------------------------------------------
	// strap latch
	// ---------------------------------------------------------------
	logic        pg_d_ff;                       // previous power good
	logic        cfg_done_ff;                   // straps captured
	logic [3:0]  rxs_ff;                        // latched rx straps
	logic [3:0]  txs_ff;                        // latched tx straps
	logic [1:0]  ser_ff;                        // latched serial strap
	logic [15:0] hold_cnt_ff;                   // hold interval counter
	logic        bias_ff;                       // strap bias enable
	wire         pg_rise = pg_s & ~pg_d_ff;     // reset release edge
	wire         hold_end = (hold_cnt_ff == 16'(CFG_HOLD_CYC - 1));

	// one level each: a 2-bit code holds exactly one of four
	// level codes: comparator output already in 00/01/10/11 order
	// strap capture: once, on rising power good
	// hold values: loading only on the rise; low power good clears only cfg_done_ff
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pg_d_ff     <= 1'b0;
			cfg_done_ff <= 1'b0;
			rxs_ff      <= {LVL_LOW, LVL_LOW};
			txs_ff      <= {LVL_LOW, LVL_LOW};
			ser_ff      <= LVL_LOW;
		end else begin
			pg_d_ff <= pg_s;
			if (!pg_s) begin
				cfg_done_ff <= 1'b0;
			end else if (pg_rise) begin
				cfg_done_ff <= 1'b1;
				rxs_ff      <= rxs_s;
				txs_ff      <= txs_s;
				ser_ff      <= ser_s;
			end
		end
	end

	// bias release: count hold interval after capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_cnt_ff <= '0;
			bias_ff     <= 1'b1;
		end else if (!pg_s) begin
			hold_cnt_ff <= '0;
			bias_ff     <= 1'b1;
		end else if (cfg_done_ff && bias_ff) begin
			hold_cnt_ff <= hold_cnt_ff + 16'h1;
			if (hold_end) begin
				bias_ff <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// register file
	// ---------------------------------------------------------------
	logic        reg_force_ff;                  // software forces reg mode
	logic [3:0]  gsel1_ff;                      // port_one_gain_select
	logic [3:0]  gsel2_ff;                      // port_two_gain_select
	logic [3:0]  gselt_ff;                      // tx_side_gain_select
	logic [31:0] nxt_prdata;
	wire         acc    = psel & penable;
	wire         wr     = acc & pwrite;
	wire         hit    = (paddr == OFS_CTRL)  | (paddr == OFS_GAIN1) |
	                      (paddr == OFS_GAIN2) | (paddr == OFS_GAINT) |
	                      (paddr == OFS_STRAP) | (paddr == OFS_STAT)  |
	                      (paddr == OFS_EQ);

	// mode select: any strap level but strong low, or software, picks registers
	wire         reg_mode = (ser_ff != LVL_LOW) | reg_force_ff;

	// software writes, only at the access edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reg_force_ff <= 1'b0;
			gsel1_ff     <= GAIN_MIN;
			gsel2_ff     <= GAIN_MIN;
			gselt_ff     <= GAIN_MIN;
		end else if (wr) begin
			if (paddr == OFS_CTRL)  reg_force_ff <= pwdata[0];
			if (paddr == OFS_GAIN1) gsel1_ff     <= pwdata[3:0];
			if (paddr == OFS_GAIN2) gsel2_ff     <= pwdata[3:0];
			if (paddr == OFS_GAINT) gselt_ff     <= pwdata[3:0];
		end
	end

	// read mux
	always_comb begin
		nxt_prdata = 32'h0;
		case (paddr)
			OFS_CTRL:  nxt_prdata = {31'h0, reg_force_ff};
			OFS_GAIN1: nxt_prdata = {28'h0, gsel1_ff};
			OFS_GAIN2: nxt_prdata = {28'h0, gsel2_ff};
			OFS_GAINT: nxt_prdata = {28'h0, gselt_ff};
			OFS_STRAP: nxt_prdata = {20'h0, cfg_done_ff, reg_mode,
			                         ser_ff, txs_ff, rxs_ff};
			OFS_STAT:  nxt_prdata = {27'h0, bias_ff, rx_term_en,
			                         link_state, 1'b0};
			OFS_EQ:    nxt_prdata = {20'h0, tx_side_eq, port_two_eq,
			                         port_one_eq};
			default:   nxt_prdata = 32'h0;
		endcase
	end

	// no wait state: pready and data registered from setup, valid in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~hit;
			prdata  <= (psel & ~penable & ~pwrite) ? nxt_prdata : 32'h0;
		end
	end

	// ---------------------------------------------------------------
	// equalization selection
	// ---------------------------------------------------------------
	// gain pack: straps arrive as {higher, lower} codes already
	// sixteen settings: pair of 2-bit codes forms 4-bit gain
	// per path: rx straps feed ports, tx straps feed tx side
	// separate channels: each output picks its own source
	wire [3:0] g1_src = reg_mode ? gsel1_ff : rxs_ff;
	wire [3:0] g2_src = reg_mode ? gsel2_ff : rxs_ff;
	wire [3:0] gt_src = reg_mode ? gselt_ff : txs_ff;

	// lfps kills eq, else chosen gain, lowest before config
	function automatic logic [3:0] eq_pick(input logic done,
	                                       input logic lfps,
	                                       input logic [3:0] src);
		eq_pick = (!done || lfps) ? GAIN_MIN : src;
	endfunction : eq_pick

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_one_eq <= GAIN_MIN;
			port_two_eq <= GAIN_MIN;
			tx_side_eq  <= GAIN_MIN;
		end else begin
			port_one_eq <= eq_pick(cfg_done_ff, lfps_s[0], g1_src);
			port_two_eq <= eq_pick(cfg_done_ff, lfps_s[1], g2_src);
			tx_side_eq  <= eq_pick(cfg_done_ff, lfps_s[2], gt_src);
		end
	end

	// ---------------------------------------------------------------
	// link state tracking
	// ---------------------------------------------------------------
	rdc_link_t   st_ff;
	rdc_link_t   nxt_st;
	logic [31:0] det_cnt_ff;                    // detect period counter
	wire         both_term = &term_s;
	wire         both_idle = &idle_s;
	wire         any_lfps  = |lfps_s;
	wire         det_tick  = (det_cnt_ff == 32'(RXDET_CYC - 1));

	// phy and timer: transitions from termination, idle, lfps and det_tick
	always_comb begin
		nxt_st = st_ff;
		case (st_ff)
			// direct to u0 once both ends terminate
			LS_DISC: if (both_term) nxt_st = LS_U0;
			LS_U0:   if (!both_term) nxt_st = LS_DISC;
			         else if (both_idle) nxt_st = LS_U1;
			LS_U1:   if (!both_term) nxt_st = LS_DISC;
			         else if (!both_idle) nxt_st = LS_U0;
			         else if (det_tick) nxt_st = LS_U23;
			LS_U23:  if (!both_term) nxt_st = LS_DISC;
			         else if (any_lfps) nxt_st = LS_U0;
			default: nxt_st = LS_DISC;
		endcase
	end

	// periodic detect while disconnected or in u2/u3
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff           <= LS_DISC;
			det_cnt_ff      <= 32'h0;
			rx_detect_pulse <= 1'b0;
		end else if (!cfg_done_ff) begin
			st_ff           <= LS_DISC;
			det_cnt_ff      <= 32'h0;
			rx_detect_pulse <= 1'b0;
		end else begin
			st_ff           <= nxt_st;
			det_cnt_ff      <= det_tick ? 32'h0 : det_cnt_ff + 32'h1;
			rx_detect_pulse <= det_tick &
			                   ((st_ff == LS_DISC) | (st_ff == LS_U23));
		end
	end

	// termination on once a receiver is found
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_term_en    <= 1'b0;
			link_state    <= 2'h0;
			strap_bias_en <= 1'b1;
		end else begin
			rx_term_en    <= (nxt_st != LS_DISC) & cfg_done_ff;
			// report disconnect while unconfigured, as the state flop does
			link_state    <= cfg_done_ff ? 2'(nxt_st) : 2'h0;
			strap_bias_en <= bias_ff;
		end
	end

endmodule : rdc_top

/* testbench/rdc_top_properties.sv */
// rdc_chk: port properties of the redriver control block
`timescale 1ns/1ps
module rdc_chk import rdc_pkg::*; #(
	parameter int RXDET_CYC = 20
) (
	// clock, reset, power good
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        power_good,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// link and gains
	input wire logic [1:0]  far_term_seen,
	input wire logic [2:0]  lfps_seen,
	input wire logic        rx_detect_pulse,
	input wire logic        rx_term_en,
	input wire logic        strap_bias_en,
	input wire logic [3:0]  port_one_eq,
	input wire logic [3:0]  port_two_eq,
	input wire logic [3:0]  tx_side_eq,
	input wire logic [1:0]  link_state
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// cycles of power good; cycles since last probe, counted while link_state is disc or u1
	logic [10:0] pg_ff;
	logic [31:0] gap_ff;
	wire         gap_clr = rx_detect_pulse || !power_good || link_state[0];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pg_ff  <= 11'h0;
			gap_ff <= 32'h0;
		end else begin
			pg_ff  <= power_good ? pg_ff + {10'h0, pg_ff != 11'h7ff} : 11'h0;
			gap_ff <= gap_clr ? 32'h0 : gap_ff + 32'h1;
		end
	end
	a_term_on_link: assert property ((link_state != 2'h0) [*2] |-> rx_term_en)
		else $error("termination off while linked");
	a_term_off_disc: assert property ((link_state == 2'h0) [*2] |-> !rx_term_en)
		else $error("termination on while disconnected");
	a_lfps_eq_off: assert property (lfps_seen[0] [*8] |-> port_one_eq == 4'h0)
		else $error("gain applied during lfps");
	a_eq_low_pre: assert property (!power_good [*8] |-> {port_one_eq, port_two_eq, tx_side_eq} == 12'h0)
		else $error("gain not lowest before power good");
	a_bias_hold: assert property ($fell(strap_bias_en) |-> pg_ff >= CFG_HOLD_CYC)
		else $error("strap bias dropped early");
	a_bias_drop: assert property (pg_ff >= CFG_HOLD_CYC + 16 |-> !strap_bias_en)
		else $error("strap bias still on");
	a_detect_gap: assert property (power_good |-> gap_ff <= RXDET_CYC + 8)
		else $error("receiver probe missing");
	a_u0_on_term: assert property ((power_good && far_term_seen == 2'h3) [*8] |-> link_state != 2'h0)
		else $error("no exit from disconnect");
	a_disc_on_drop: assert property ((far_term_seen != 2'h3) [*8] |-> link_state == 2'h0)
		else $error("linked without termination");
	a_lfps_wakes: assert property ((lfps_seen != 3'h0 && far_term_seen == 2'h3) [*8] |-> link_state != 2'h3)
		else $error("lfps did not wake link");
	a_apb_answer: assert property (psel && !penable |=> pready)
		else $error("apb answer late");
	a_bad_addr: assert property (psel && !penable && paddr > 8'h18 |=> pslverr && prdata == 32'h0)
		else $error("unmapped access accepted");
	cover property (link_state == 2'h3);
	cover property ($fell(strap_bias_en));
	cover property (pslverr && pready);
endmodule : rdc_chk

bind rdc_top rdc_chk #(.RXDET_CYC(RXDET_CYC)) i_chk (
	.pclk(pclk), .presetn(presetn), .power_good(power_good),
	.psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .far_term_seen(far_term_seen),
	.lfps_seen(lfps_seen), .rx_detect_pulse(rx_detect_pulse),
	.rx_term_en(rx_term_en), .strap_bias_en(strap_bias_en),
	.port_one_eq(port_one_eq), .port_two_eq(port_two_eq),
	.tx_side_eq(tx_side_eq), .link_state(link_state));

/* testbench/rdc_link_model.sv */
// rdc_link_model: far-side receiver and line conditions
`timescale 1ns/1ps
module rdc_link_model (
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// commands from the bench
	input  wire logic       attach,
	input  wire logic       slow,
	input  wire logic       idle,
	input  wire logic [2:0] lfps,
	// probe from the block
	input  wire logic       rx_detect_pulse,
	// seen by the block
	output logic      [1:0] far_term_seen,
	output logic      [1:0] elec_idle,
	output logic      [2:0] lfps_seen
);
	logic skip_ff; // a slow receiver misses its first probe
	// termination shows only once probed, so a missed probe must be retried
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			far_term_seen <= 2'h0;
			skip_ff       <= 1'b0;
		end else if (!attach) begin
			far_term_seen <= 2'h0;
			skip_ff       <= slow;
		end else if (rx_detect_pulse) begin
			skip_ff <= 1'b0;
			if (!skip_ff) far_term_seen <= 2'h3;
		end
	end
	assign elec_idle = {2{idle && attach}};
	assign lfps_seen = lfps;
endmodule : rdc_link_model

/* testbench/tb_redriver_config_eq_control.sv */
// tb_redriver_config_eq_control: self-checking bench for rdc_top
`timescale 1ns/1ps
module tb_redriver_config_eq_control;
	import rdc_pkg::*;
	localparam int RXD = 20; // short probe period
	logic        pclk, presetn, power_good, psel, penable, pwrite, er;
	logic        pready, pslverr, rx_detect_pulse, rx_term_en;
	logic        strap_bias_en, attach, slow, idle;
	logic [1:0]  ser_st, far_term_seen, elec_idle, link_state;
	logic [2:0]  lfps_seen, lfps_cmd;
	logic [3:0]  rx_st, tx_st, port_one_eq, port_two_eq, tx_side_eq;
	logic [3:0]  g1, g2, gt;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	int          err_count, compares, seed, n;
	rdc_top #(.RXDET_CYC(RXD)) i_dut (
		.pclk(pclk), .presetn(presetn), .power_good(power_good),
		.rx_port_gain_straps(rx_st), .tx_side_gain_straps(tx_st),
		.serial_cfg_strap(ser_st), .far_term_seen(far_term_seen),
		.elec_idle(elec_idle), .lfps_seen(lfps_seen), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_detect_pulse(rx_detect_pulse),
		.rx_term_en(rx_term_en), .strap_bias_en(strap_bias_en),
		.port_one_eq(port_one_eq), .port_two_eq(port_two_eq),
		.tx_side_eq(tx_side_eq), .link_state(link_state));
	rdc_link_model i_link (
		.pclk(pclk), .presetn(presetn), .attach(attach), .slow(slow),
		.idle(idle), .lfps(lfps_cmd), .rx_detect_pulse(rx_detect_pulse),
		.far_term_seen(far_term_seen), .elec_idle(elec_idle),
		.lfps_seen(lfps_seen));
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	task automatic cyc(input int k);
		repeat (k) @(posedge pclk);
	endtask : cyc
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// straps change only while power good is low, then latch at its rise
	task automatic latch(input logic [3:0] r, input logic [3:0] t, input logic [1:0] s);
		power_good <= 1'b0;
		cyc(8);
		rx_st <= r;
		tx_st <= t;
		ser_st <= s;
		cyc(2);
		power_good <= 1'b1;
		cyc(12);
	endtask : latch
	function automatic logic [3:0] exp_gain(input logic lf, input logic [3:0] v);
		return lf ? GAIN_MIN : v;
	endfunction : exp_gain
	task complete_run;
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : complete_run
	initial begin
		#400000;
		err_count++;
		complete_run;
	end
	initial begin
		seed = 62;
		{presetn, power_good, psel, penable, pwrite} <= 5'h0;
		{paddr, pwdata, rx_st, tx_st, ser_st} <= 50'h0;
		{attach, slow, idle, lfps_cmd} <= 6'h0;
		cyc(4);
		presetn <= 1'b1;
		cyc(8);
		chk("eq pre", 32'h1, {port_one_eq, port_two_eq, tx_side_eq, strap_bias_en});
		for (int i = 0; i < 16; i++) begin
			g1 = i[3:0];
			gt = 4'($random(seed));
			latch(g1, gt, 2'h0);
			chk("straps", {g1, g1, gt, 1'b1}, {port_one_eq, port_two_eq, tx_side_eq, strap_bias_en});
			rx_st <= ~g1;
			tx_st <= ~gt;
			cyc(12);
			chk("held", {g1, gt}, {port_one_eq, tx_side_eq});
		end
		for (int b = 0; b < 4; b++) begin
			lfps_cmd <= 3'(4'h1 << b);
			cyc(10);
			chk("lfps", {exp_gain(b == 0, g1), exp_gain(b == 1, g1), exp_gain(b == 2, gt)}, {port_one_eq, port_two_eq, tx_side_eq});
		end
		cyc(CFG_HOLD_CYC);
		chk("bias off", 32'h0, strap_bias_en);
		{g1, g2, gt} = 12'($random(seed));
		apb(1'b1, OFS_GAIN1, {28'h0, g1});
		apb(1'b1, OFS_GAIN2, {28'h0, g2});
		apb(1'b1, OFS_GAINT, {28'h0, gt});
		apb(1'b0, OFS_GAIN2, 32'h0);
		chk("gain reg", {28'h0, g2}, rd);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, er});
		chk("unmapped data", 32'h0, rd);
		for (int s = 1; s < 4; s++) begin
			latch(~g1, ~gt, s[1:0]);
			chk("reg mode", {g1, g2, gt}, {port_one_eq, port_two_eq, tx_side_eq});
		end
		apb(1'b1, OFS_CTRL, 32'h1);
		latch(~g1, ~gt, 2'h0);
		chk("forced", {g1, g2, gt}, {port_one_eq, port_two_eq, tx_side_eq});
		apb(1'b0, OFS_STRAP, 32'h0);
		chk("strap reg", {20'h0, 2'h3, 2'h0, ~gt, ~g1}, rd);
		apb(1'b1, OFS_CTRL, 32'h0);
		slow <= 1'b1;
		cyc(1);
		attach <= 1'b1;
		n = 0;
		repeat (3 * RXD) begin
			@(posedge pclk);
			n += int'(rx_detect_pulse);
		end
		chk("linked", {1'b1, 2'h1, 1'b1}, {n >= 2, link_state, rx_term_en});
		idle <= 1'b1;
		n = 0;
		while (link_state === 2'h1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		chk("u1", 32'h2, link_state);
		cyc(3 * RXD);
		chk("u23", 32'h3, link_state);
		idle <= 1'b0;
		lfps_cmd <= 3'h1;
		cyc(10);
		chk("wake", 32'h1, link_state);
		lfps_cmd <= 3'h0;
		attach <= 1'b0;
		cyc(10);
		chk("unplug", 32'h0, {link_state, rx_term_en});
		presetn <= 1'b0;
		cyc(2);
		chk("reset", 32'h1, {port_one_eq, port_two_eq, tx_side_eq, strap_bias_en});
		presetn <= 1'b1;
		cyc(30);
		complete_run;
	end
endmodule : tb_redriver_config_eq_control
